// >>> frame_call_unit.v
// Procedure call and return frame management unit.
`timescale 1ns/100ps
`include "frame_call_map.vh"
module frame_call_unit (
  // Clock and reset.
  input  wire        clk,
  input  wire        arst_n,
  // Call and return requests.
  input  wire        call_req,
  input  wire [2:0]  call_type,
  input  wire [31:0] next_ip,
  input  wire [31:0] target_operand,
  input  wire [31:0] table_target,
  input  wire [31:0] interrupt_sp,
  input  wire [31:0] privileged_stack_pointer,
  input  wire        user_mode,
  input  wire        interrupted,
  input  wire        return_instr,
  output wire        busy,
  output reg         done_q,
  // Software local register access.
  input  wire        lreg_we,
  input  wire [3:0]  lreg_waddr,
  input  wire [31:0] lreg_wdata,
  input  wire [3:0]  lreg_raddr,
  output reg  [31:0] lreg_rdata_q,
  output reg         bad_operand_fault_q,
  // Architectural state.
  output reg  [31:0] frame_base_pointer_q,
  output reg  [31:0] instr_pointer_q,
  output reg  [3:0]  return_type_q,
  output wire [31:0] stack_top_pointer,
  // Memory port for spill and fill.
  output reg         mem_req_q,
  output reg         mem_we_q,
  output reg  [31:0] mem_addr_q,
  output reg  [31:0] mem_wdata_q,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_SAVE  = 3'h1;
  localparam ST_SPILL = 3'h2;
  localparam ST_FILL  = 3'h3;
  localparam ST_LOAD  = 3'h4;
  localparam ST_FIN   = 3'h5;

  // Rounds an address up to the next aligned frame start.
  function [31:0] align_up;
    input [31:0] a;
    begin
      align_up = (a + `ALIGN_ADD) & `ALIGN_MASK;
    end
  endfunction

  // Maps a set slot and register index to a cache memory word.
  function [5:0] cache_addr;
    input [1:0] slot;
    input [3:0] idx;
    begin
      cache_addr = {slot, idx};
    end
  endfunction

  // Encodes the return type recorded for a call.
  function [3:0] ret_code;
    input [2:0] ctype;
    input       umode;
    begin
      if ((ctype == `CT_SYS_SUPER) && umode) begin
        ret_code = `RT_SUPER;
      end else if (ctype == `CT_INTERRUPT) begin
        ret_code = `RT_INTERRUPT;
      end else if (ctype == `CT_FAULT) begin
        ret_code = `RT_FAULT;
      end else begin
        ret_code = `RT_LOCAL;
      end
    end
  endfunction

  reg [31:0] lregs [0:15];
  reg [31:0] slot_fp_q [0:3];
  reg [2:0]  state_q;
  reg [4:0]  cnt_q;
  reg [1:0]  head_q;
  reg [2:0]  used_q;
  reg [31:0] new_fp_q;
  reg [31:0] new_ip_q;
  reg [3:0]  new_rt_q;
  reg        ret_q;
  reg [5:0]  mem_waddr;
  reg [31:0] mem_wdat;
  reg        mem_wen;
  reg [5:0]  mem_raddr;
  wire [31:0] cache_rdata;
  wire [1:0]  tail_slot;
  wire [1:0]  new_head;
  wire [3:0]  spill_idx;
  integer i;

  assign busy = (state_q != ST_IDLE);
  assign stack_top_pointer = lregs[`IDX_SP];
  assign tail_slot = head_q - used_q[1:0];
  assign new_head = head_q + 2'h1;
  assign spill_idx = (mem_req_q && mem_ack) ? cnt_q[3:0] + 4'h1 : cnt_q[3:0];

  lreg_cache_mem u_mem (
    .clk     (clk),
    .wr_en   (mem_wen),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdat),
    .rd_addr (mem_raddr),
    .rd_data (cache_rdata)
  );

  // Cache write and read addressing by state.
  always @* begin
    mem_wen   = 1'b0;
    mem_waddr = cache_addr(head_q, cnt_q[3:0]);
    mem_wdat  = lregs[cnt_q[3:0]];
    mem_raddr = cache_addr(head_q, cnt_q[3:0]);
    if (state_q == ST_SAVE) begin
      mem_wen = 1'b1;
    end
    if (state_q == ST_IDLE) begin
      mem_raddr = cache_addr(tail_slot, 4'h0);
    end
    if (state_q == ST_SPILL) begin
      mem_raddr = cache_addr(tail_slot, spill_idx);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      head_q <= 2'h0;
      used_q <= 3'h0;
      new_fp_q <= 32'h00000000;
      new_ip_q <= 32'h00000000;
      new_rt_q <= 4'h0;
      ret_q <= 1'b0;
      done_q <= 1'b0;
      lreg_rdata_q <= 32'h00000000;
      bad_operand_fault_q <= 1'b0;
      frame_base_pointer_q <= 32'h00000000;
      instr_pointer_q <= 32'h00000000;
      return_type_q <= 4'h0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 32'h00000000;
      mem_wdata_q <= 32'h00000000;
      for (i = 0; i < 16; i = i + 1) begin
        lregs[i] <= 32'h00000000;
      end
      for (i = 0; i < `CACHE_SETS; i = i + 1) begin
        slot_fp_q[i] <= 32'h00000000;
      end
    end else begin
      done_q <= 1'b0;
      bad_operand_fault_q <= 1'b0;
      lreg_rdata_q <= lregs[lreg_raddr];
      case (state_q)
        ST_IDLE: begin
          if (call_req) begin
            lregs[`IDX_RIP] <= next_ip;
            new_rt_q <= ret_code(call_type, user_mode);
            if ((call_type == `CT_INTERRUPT) && user_mode && !interrupted) begin
              new_fp_q <= align_up(interrupt_sp);
            end else if ((call_type == `CT_SYS_SUPER) && user_mode) begin
              new_fp_q <= align_up(privileged_stack_pointer);
            end else begin
              new_fp_q <= align_up(lregs[`IDX_SP]);
            end
            if (call_type == `CT_LOCAL) begin
              new_ip_q <= target_operand;
            end else begin
              new_ip_q <= table_target;
            end
            cnt_q <= 5'h00;
            ret_q <= 1'b0;
            if (used_q == `CACHE_SETS) begin
              state_q <= ST_SPILL;
            end else begin
              state_q <= ST_SAVE;
            end
          end else if (return_instr) begin
            ret_q <= 1'b1;
            new_rt_q <= lregs[`IDX_PFP][3:0];
            frame_base_pointer_q <= lregs[`IDX_PFP] & `ALIGN_MASK;
            cnt_q <= 5'h00;
            if (used_q != 3'h0) begin
              head_q <= head_q - 2'h1;
              used_q <= used_q - 3'h1;
              state_q <= ST_LOAD;
            end else begin
              state_q <= ST_FILL;
            end
          end else if (lreg_we) begin
            if (lreg_waddr == `IDX_RIP) begin
              bad_operand_fault_q <= 1'b1;
            end else begin
              lregs[lreg_waddr] <= lreg_wdata;
            end
          end
        end
        ST_SPILL: begin
          if (!mem_req_q) begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b1;
            mem_wdata_q <= cache_rdata;
            mem_addr_q <= slot_fp_q[tail_slot] + {26'h0000000, cnt_q[3:0], 2'b00};
          end else if (mem_ack) begin
            mem_req_q <= 1'b0;
            if (cnt_q == `NUM_LOCALS - 5'h01) begin
              cnt_q <= 5'h00;
              used_q <= used_q - 3'h1;
              state_q <= ST_SAVE;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        ST_SAVE: begin
          if (cnt_q == `NUM_LOCALS - 5'h01) begin
            head_q <= new_head;
            used_q <= used_q + 3'h1;
            frame_base_pointer_q <= new_fp_q;
            lregs[`IDX_SP] <= new_fp_q + `SAVE_AREA;
            lregs[`IDX_PFP] <= (frame_base_pointer_q & `ALIGN_MASK) |
              {28'h0000000, new_rt_q};
            slot_fp_q[head_q] <= frame_base_pointer_q;
            return_type_q <= new_rt_q;
            state_q <= ST_FIN;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_LOAD: begin
          if (cnt_q != 5'h00) begin
            lregs[cnt_q[3:0] - 4'h1] <= cache_rdata;
          end
          if (cnt_q == `NUM_LOCALS) begin
            state_q <= ST_FIN;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_FILL: begin
          if (!mem_req_q) begin
            mem_req_q <= 1'b1;
            mem_we_q <= 1'b0;
            mem_addr_q <= frame_base_pointer_q + {26'h0000000, cnt_q[3:0], 2'b00};
          end else if (mem_ack) begin
            mem_req_q <= 1'b0;
            lregs[cnt_q[3:0]] <= mem_rdata;
            if (cnt_q == `NUM_LOCALS - 5'h01) begin
              state_q <= ST_FIN;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        ST_FIN: begin
          if (ret_q) begin
            instr_pointer_q <= lregs[`IDX_RIP];
            return_type_q <= new_rt_q;
          end else begin
            instr_pointer_q <= new_ip_q;
          end
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> frame_call_map.vh
// Constants for the procedure frame call and return unit.
`ifndef FRAME_CALL_MAP_VH
`define FRAME_CALL_MAP_VH
`define ALIGN_MASK      32'hFFFFFFF0
`define ALIGN_ADD       32'h0000000F
`define SAVE_AREA       32'h00000040
`define RT_MASK         32'h0000000F
`define SET_BYTES       32'h00000004
`define NUM_LOCALS      5'h10
`define LREG_AW         4
`define CACHE_SETS      3'h4
`define CACHE_AW        2
`define CACHE_DEPTH     6'h20
`define MEM_AW          6
`define IDX_PFP         4'h0
`define IDX_SP          4'h1
`define IDX_RIP         4'h2
`define CT_LOCAL        3'h0
`define CT_SYS_LOCAL    3'h1
`define CT_SYS_SUPER    3'h2
`define CT_INTERRUPT    3'h3
`define CT_FAULT        3'h4
`define RT_LOCAL        4'h0
`define RT_FAULT        4'h1
`define RT_SUPER        4'h2
`define RT_INTERRUPT    4'h7
`endif

// >>> lreg_cache_mem.v
// Register-file memory holding the cached local register sets.
`timescale 1ns/100ps
`include "frame_call_map.vh"
module lreg_cache_mem (
  // Clock.
  input  wire        clk,
  // Write port.
  input  wire        wr_en,
  input  wire [5:0]  wr_addr,
  input  wire [31:0] wr_data,
  // Read port.
  input  wire [5:0]  rd_addr,
  output reg  [31:0] rd_data
);
  reg [31:0] mem [0:63];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// >>> frame_call_unit_chk.sv
// Assertions on the frame call unit ports.
`timescale 1ns/100ps
`include "frame_call_map.vh"
module frame_call_unit_chk (
  // Clock and reset.
  input wire        clk,
  input wire        arst_n,
  // Requests.
  input wire        call_req,
  input wire [2:0]  call_type,
  input wire [31:0] target_operand,
  input wire [31:0] table_target,
  input wire        return_instr,
  input wire        lreg_we,
  input wire [3:0]  lreg_waddr,
  // State and memory.
  input wire        busy,
  input wire        done_q,
  input wire        bad_operand_fault_q,
  input wire [31:0] frame_base_pointer_q,
  input wire [31:0] instr_pointer_q,
  input wire [31:0] stack_top_pointer,
  input wire        mem_req_q,
  input wire        mem_ack,
  input wire [31:0] mem_addr_q
);
  reg  call_op_q;
  wire take = !busy && (call_req || return_instr);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Remembers whether the running operation is a call.
  always @(posedge clk or negedge arst_n)
    if (!arst_n) call_op_q <= 1'b0;
    else if (!busy) call_op_q <= call_req;
  take_busy_a: assert property (take |=> busy) else $error("Take ignored");
  call_time_a: assert property (take && call_req |-> ##[18:600] done_q)
    else $error("Call late");
  ret_time_a: assert property (take && !call_req |-> ##[18:600] done_q)
    else $error("Return late");
  idle_hold_a: assert property (!busy && !call_req && !return_instr |=>
    $stable(frame_base_pointer_q)) else $error("Frame moved");
  fp_align_a: assert property (done_q |-> frame_base_pointer_q[3:0] == 4'h0)
    else $error("Frame unaligned");
  sp_new_a: assert property (done_q && call_op_q |->
    stack_top_pointer == frame_base_pointer_q + `SAVE_AREA) else $error("Bad top");
  ip_load_a: assert property (done_q && call_op_q |-> instr_pointer_q ==
    (call_type == `CT_LOCAL ? target_operand : table_target)) else $error("Bad ip");
  r2_fault_a: assert property (!busy && lreg_we && !call_req && !return_instr &&
    lreg_waddr == `IDX_RIP |=> bad_operand_fault_q) else $error("No fault");
  fault_cause_a: assert property (bad_operand_fault_q |->
    $past(lreg_we) && $past(lreg_waddr) == `IDX_RIP) else $error("Stray fault");
  mem_hold_a: assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q))
    else $error("Request dropped");
  cover property (take && call_req);
  cover property (take && !call_req);
  cover property (mem_req_q && mem_ack);
endmodule
bind frame_call_unit frame_call_unit_chk chk (.clk, .arst_n, .call_req, .call_type,
  .target_operand, .table_target, .return_instr, .lreg_we, .lreg_waddr, .busy, .done_q,
  .bad_operand_fault_q, .frame_base_pointer_q, .instr_pointer_q, .stack_top_pointer,
  .mem_req_q, .mem_ack, .mem_addr_q);

// >>> stack_mem_model.sv
// Stack memory answering spill and fill requests.
`timescale 1ns/100ps
module stack_mem_model (
  // Clock and answer delay.
  input  wire logic        clk,
  input  wire logic [1:0]  lat,
  // Request.
  input  wire logic        mem_req_q,
  input  wire logic        mem_we_q,
  input  wire logic [31:0] mem_addr_q,
  input  wire logic [31:0] mem_wdata_q,
  // Answer.
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] m [logic [31:0]];
  integer      w = 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
  end
  // Answers after lat waits; read data is scrambled outside the answer cycle.
  always @(posedge clk) begin
    if (mem_req_q && !mem_ack && w >= lat) begin
      w = 0;
      mem_ack <= 1'b1;
      if (mem_we_q) m[mem_addr_q] = mem_wdata_q;
      mem_rdata <= mem_we_q ? ~mem_rdata : m.exists(mem_addr_q) ? m[mem_addr_q] : ~mem_addr_q;
    end else begin
      w = mem_req_q ? w + 1 : 0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// >>> procedure_frame_call_return_tb.sv
// Self-checking bench for the frame call unit.
`timescale 1ns/100ps
`include "frame_call_map.vh"
module procedure_frame_call_return_tb;
  logic        clk = 0, arst_n = 0, call_req = 0, user_mode = 0, interrupted = 0;
  logic        return_instr = 0, lreg_we = 0, busy, done_q, bad_operand_fault_q;
  logic        mem_req_q, mem_we_q, mem_ack;
  logic [1:0]  lat = 0;
  logic [2:0]  call_type = 0;
  logic [3:0]  lreg_waddr = 0, lreg_raddr = 0, return_type_q, rt;
  logic [31:0] next_ip = 0, target_operand = 0, table_target = 0, interrupt_sp = 0;
  logic [31:0] privileged_stack_pointer = 0, lreg_wdata = 0, lreg_rdata_q;
  logic [31:0] frame_base_pointer_q, instr_pointer_q, stack_top_pointer;
  logic [31:0] mem_addr_q, mem_wdata_q, mem_rdata, fp = 0, sp = `SAVE_AREA, base;
  logic [31:0] q_fp[$], q_sp[$], q_ip[$];
  integer      seed = 49066, err_total = 0, checks = 0, k, i;
  always #25 clk = ~clk;
  frame_call_unit DUT (.clk, .arst_n, .call_req, .call_type, .next_ip, .target_operand,
    .table_target, .interrupt_sp, .privileged_stack_pointer, .user_mode, .interrupted,
    .return_instr, .busy, .done_q, .lreg_we, .lreg_waddr, .lreg_wdata, .lreg_raddr,
    .lreg_rdata_q, .bad_operand_fault_q, .frame_base_pointer_q, .instr_pointer_q,
    .return_type_q, .stack_top_pointer, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q,
    .mem_ack, .mem_rdata);
  stack_mem_model mem (.clk, .lat, .mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q,
    .mem_ack, .mem_rdata);
  task automatic chk(input logic [31:0] s, e, input string m);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fin;
    for (i = 0; i < 900 && done_q !== 1'b1; i++) @(posedge clk) #1;
    chk(done_q, 1, "no done");
    lat = 2'($random(seed));
  endtask
  task automatic do_call(input logic [2:0] t, input logic um, ii);
    call_type = t; user_mode = um; interrupted = ii; call_req = 1;
    next_ip = $random(seed); target_operand = $random(seed); table_target = $random(seed);
    interrupt_sp = $random(seed); privileged_stack_pointer = $random(seed);
    @(posedge clk) #1 call_req = 0;
    return_instr = 1;
    @(posedge clk) #1 return_instr = 0;
    base = (t == `CT_INTERRUPT && um && !ii) ? interrupt_sp :
           (t == `CT_SYS_SUPER && um) ? privileged_stack_pointer : sp;
    rt = t == `CT_INTERRUPT ? `RT_INTERRUPT : t == `CT_FAULT ? `RT_FAULT :
         (t == `CT_SYS_SUPER && um) ? `RT_SUPER : `RT_LOCAL;
    q_fp.push_back(fp); q_sp.push_back(sp); q_ip.push_back(next_ip);
    fp = (base + `ALIGN_ADD) & `ALIGN_MASK;
    sp = fp + `SAVE_AREA;
    fin;
    chk(frame_base_pointer_q, fp, "call fp");
    chk(stack_top_pointer, sp, "call sp");
    chk(instr_pointer_q, t == `CT_LOCAL ? target_operand : table_target, "ip");
    chk(return_type_q, rt, "rtype");
    @(posedge clk) #1;
    chk(lreg_rdata_q, {q_fp[$][31:4], rt}, "link");
  endtask
  task automatic do_ret;
    return_instr = 1;
    @(posedge clk) #1 return_instr = 0;
    fp = q_fp.pop_back();
    sp = q_sp.pop_back();
    fin;
    chk(frame_base_pointer_q, fp, "ret fp");
    chk(stack_top_pointer, sp, "ret sp");
    chk(instr_pointer_q, q_ip.pop_back(), "ret ip");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 arst_n = 1;
    for (k = 0; k < 2; k++) begin
      lreg_we = 1; lreg_waddr = k ? `IDX_RIP : `IDX_SP;
      lreg_wdata = k ? $random(seed) : sp;
      @(posedge clk) #1 lreg_we = 0;
      chk(bad_operand_fault_q, k, "r2 write");
      chk(stack_top_pointer, sp, "sw top");
      @(posedge clk) #1;
    end
    $display("local writes done");
    for (k = 0; k < 8; k++) do_call(k == 7 ? `CT_SYS_SUPER : k == 6 ? `CT_INTERRUPT : 3'(k % 5),
      k < 5 || k == 6, k == 6 ? 1'b1 : k > 4 ? 1'($random(seed)) : 1'b0);
    $display("calls done");
    for (k = 0; k < 8; k++) do_ret;
    $display("returns done");
    wrap_up;
  end
  initial begin
    #1000000;
    err_total++;
    wrap_up;
  end
endmodule
